// ### rtl/scb_pkg.sv
// Purpose: shared constants and state type of the serial controller host port
// Assumes: one clock, registers reached over the 8-bit host port
// Notes: register selects and bit positions are named here once
package scb_pkg;
   // register select codes, shared by read and write direction
   localparam logic [1:0] SEL_DATA = 2'h0; // tx/rx holding registers
   localparam logic [1:0] SEL_SYNC = 2'h1; // sync chars on write, status on read
   localparam logic [1:0] SEL_MODE = 2'h2; // mode registers 1 and 2, pointer stepped
   localparam logic [1:0] SEL_CMD = 2'h3; // command register
   // command register bit positions
   localparam int CMD_TXEN = 0;
   localparam int CMD_DTR = 1;
   localparam int CMD_RXEN = 2;
   localparam int CMD_RTS = 5;
   // mode register 1 bit positions: 00 in [1:0] selects synchronous operation
   localparam int MR1_MODE_LO = 0;
   localparam int MR1_MODE_HI = 1;
   // status register bit positions
   localparam int ST_TX_HOLDING_READY_N = 0;
   localparam int ST_RX_HOLDING_READY_N = 1;
   localparam int ST_CHG = 2;
   localparam int ST_DCD = 6;
   localparam int ST_DSR = 7;
   // sub-count for 16x to 1x in asynchronous mode
   localparam logic [3:0] SUB_LAST = 4'hf;
   localparam int DIV_W = 13;

   // all state of the host port
   typedef struct packed {
      logic [7:0] mr1, mr2, cmd, syn1, syn2, dle, tx_holding_register, rx_holding_register, dout;
      logic dout_en, mptr;
      logic [1:0] sptr;
      logic thr_full, rx_rdy, chg, tx_emt;
      logic ce_seen, dsr_prev, dcd_prev, ref_prev;
      logic [DIV_W-1:0] bcnt;
      logic [3:0] sub;
      logic t16, txb, rxb, txr_oe, rxr_oe, emt_oe, dtr_n, rts_n;
   } scb_state_t;

   localparam scb_state_t SCB_RST = '{dtr_n: 1'b1, rts_n: 1'b1, default: '0};

   // divisor table of the first rate set, reference clock edges per 16x tick
   function automatic logic [DIV_W-1:0] scb_divisor(input logic [3:0] code);
      case (code)
         4'h0: scb_divisor = 13'd6144;
         4'h1: scb_divisor = 13'd4096;
         4'h2: scb_divisor = 13'd2793;
         4'h3: scb_divisor = 13'd2284;
         4'h4: scb_divisor = 13'd2048;
         4'h5: scb_divisor = 13'd1536;
         4'h6: scb_divisor = 13'd1024;
         4'h7: scb_divisor = 13'd512;
         4'h8: scb_divisor = 13'd292;
         4'h9: scb_divisor = 13'd256;
         4'ha: scb_divisor = 13'd171;
         4'hb: scb_divisor = 13'd154;
         4'hc: scb_divisor = 13'd128;
         4'hd: scb_divisor = 13'd64;
         4'he: scb_divisor = 13'd32;
         default: scb_divisor = 13'd16;
      endcase
   endfunction
endpackage

// ### rtl/scb_host_port.sv
// Purpose: host register port, status pins and baud generator of the controller
// Assumes: host pins and baud reference are synchronous to clk
// Notes: character framing lives outside; it hands characters in and takes them out
`timescale 1ns/1ns
// How it works
// - reset clears buffers, command and status
// - read/write low reads, high writes
// - access only with chip enable low
// - select lines plus direction pick register
// - eight-bit data bus, bit 0 least
// - tx ready pin is inverse status bit 0 while transmit enabled
// - rx ready pin low while character waits
// - rx ready released on read or disable
// - empty/change pin low on empty or on line change while tx or rx enabled
// - status read releases only if not empty
// - four-bit mode 2 field picks rate
// - reference divided per code into 16x
// - async 16x, sync 1x transmit only
// - three host-written sync/escape char registers
// - three modem inputs, two modem outputs
// - two mode, command and status registers
module scb_host_port
   import scb_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce_n, // chip enable, low active
   input wire logic rw, // low read, high write
   input wire logic [1:0] register_select,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe, // high while the port drives the data bus
   output logic tx_holding_ready_n_oe, // pulls the ready line low
   output logic rx_holding_ready_n_oe,
   output logic tx_empty_or_line_change_n_oe,
   input wire logic baud_reference_clock,
   output logic tick_16x, // one pulse per divided reference period
   output logic tx_bit_tick, // transmit bit strobe
   output logic rx_bit_tick, // receive bit strobe, async only
   input wire logic dsr_n,
   input wire logic dcd_n,
   input wire logic cts_n,
   output logic dtr_n,
   output logic rts_n,
   output logic [7:0] tx_char, // holding register toward transmitter
   output logic tx_char_full, // holding register has a character
   input wire logic tx_shift_take, // transmitter took the holding register
   input wire logic tx_shift_done, // last bit of the character went out
   input wire logic rx_char_valid, // receiver assembled a character
   input wire logic [7:0] rx_char,
   output logic [7:0] sync1_char,
   output logic [7:0] sync2_char,
   output logic [7:0] escape_char,
   output logic [7:0] mode1,
   output logic tx_enable, // transmitter allowed to run
   output logic rx_enable // receiver allowed to run
);
   // reset release synchroniser; assertion is immediate, release is two edges late
   logic rst_meta_q, rst_n_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   scb_state_t s_q, s_d; // whole state and its next value
   logic acc, wr, rd; // first cycle of a chip-enabled access
   logic ref_edge, async_mode;
   logic [7:0] status;
   logic [DIV_W-1:0] div_sel;

   always_comb begin
      acc = !ce_n && !s_q.ce_seen;
      wr = acc && rw;
      rd = acc && !rw;
      ref_edge = baud_reference_clock && !s_q.ref_prev;
      async_mode = (s_q.mr1[MR1_MODE_HI:MR1_MODE_LO] != 2'h0);
      div_sel = scb_divisor(s_q.mr2[3:0]);
      // status byte; error bits belong to the receiver and read as zero here
      status = 8'h00;
      status[ST_TX_HOLDING_READY_N] = !s_q.thr_full;
      status[ST_RX_HOLDING_READY_N] = s_q.rx_rdy;
      status[ST_CHG] = s_q.chg;
      status[ST_DCD] = !dcd_n;
      status[ST_DSR] = !dsr_n;
   end

   // next state: host accesses, status flags, baud divider, pins
   always_comb begin
      s_d = s_q;
      s_d.ce_seen = !ce_n; // one access per chip-enable low period
      s_d.dsr_prev = dsr_n;
      s_d.dcd_prev = dcd_n;
      s_d.ref_prev = baud_reference_clock;
      s_d.t16 = 1'b0;
      s_d.txb = 1'b0;
      s_d.rxb = 1'b0;

      // holding register taken by the transmitter
      if (tx_shift_take) begin
         s_d.thr_full = 1'b0;
      end
      // transmitter drained with nothing left to send
      if (tx_shift_done && !s_q.thr_full) begin
         s_d.tx_emt = 1'b1;
      end

      // host writes, register picked by select and direction
      if (wr) begin
         case (register_select)
            SEL_DATA: begin
               s_d.tx_holding_register = data_in;
               s_d.thr_full = 1'b1;
               s_d.tx_emt = 1'b0; // loading ends the empty condition
               s_d.chg = 1'b0;
            end
            SEL_SYNC: begin
               // sync1, sync2, escape in turn
               case (s_q.sptr)
                  2'h0: s_d.syn1 = data_in;
                  2'h1: s_d.syn2 = data_in;
                  default: s_d.dle = data_in;
               endcase
               s_d.sptr = (s_q.sptr == 2'h2) ? 2'h0 : s_q.sptr + 2'h1;
            end
            SEL_MODE: begin
               if (s_q.mptr) begin
                  s_d.mr2 = data_in;
               end else begin
                  s_d.mr1 = data_in;
               end
               s_d.mptr = !s_q.mptr;
            end
            SEL_CMD: s_d.cmd = data_in;
            default: ;
         endcase
      end

      // host reads; output byte is registered, one cycle behind the access
      s_d.dout_en = !ce_n && !rw; // bus released on the clock edge after chip enable rises
      if (rd) begin
         case (register_select)
            SEL_DATA: begin
               s_d.dout = s_q.rx_holding_register;
               s_d.rx_rdy = 1'b0;
            end
            SEL_SYNC: begin
               s_d.dout = status;
               if (!s_q.tx_emt) begin
                  s_d.chg = 1'b0;
               end
            end
            SEL_MODE: begin
               s_d.dout = s_q.mptr ? s_q.mr2 : s_q.mr1;
               s_d.mptr = !s_q.mptr;
            end
            SEL_CMD: begin
               s_d.dout = s_q.cmd;
               // reading the command word rewinds both pointers
               s_d.mptr = 1'b0;
               s_d.sptr = 2'h0;
            end
            default: s_d.dout = 8'h00;
         endcase
      end

      // receiver disabled drops a waiting character flag
      if (!s_q.cmd[CMD_RXEN]) begin
         s_d.rx_rdy = 1'b0;
      end
      // new character; set wins over a same-cycle read
      if (rx_char_valid && s_q.cmd[CMD_RXEN]) begin
         s_d.rx_holding_register = rx_char;
         s_d.rx_rdy = 1'b1;
      end
      // change flag; events win over a same-cycle status read
      if ((tx_shift_done && !s_q.thr_full) ||
          ((s_q.cmd[CMD_TXEN] || s_q.cmd[CMD_RXEN]) &&
           ((dsr_n != s_q.dsr_prev) || (dcd_n != s_q.dcd_prev)))) begin
         s_d.chg = 1'b1;
      end

      // baud divider counts reference edges, reloads at terminal count
      if (ref_edge) begin
         if (s_q.bcnt == '0) begin
            s_d.bcnt = div_sel - 13'd1;
            s_d.t16 = 1'b1;
            s_d.sub = s_q.sub + 4'h1;
            if (async_mode) begin
               // 16x clock divided down to one bit per sixteen ticks
               s_d.txb = (s_q.sub == SUB_LAST);
               s_d.rxb = (s_q.sub == SUB_LAST);
            end else begin
               s_d.txb = 1'b1; // 1x, receive clock comes from outside
            end
         end else begin
            s_d.bcnt = s_q.bcnt - 13'd1;
         end
      end

      // open-drain pins: enable high pulls the line low
      s_d.txr_oe = !s_d.thr_full && s_d.cmd[CMD_TXEN];
      s_d.rxr_oe = s_d.rx_rdy;
      s_d.emt_oe = s_d.chg;
      s_d.dtr_n = !s_d.cmd[CMD_DTR];
      s_d.rts_n = !s_d.cmd[CMD_RTS];
   end

   // state register; reset clears buffers, command and status
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         s_q <= SCB_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign data_out = s_q.dout;
   assign data_oe = s_q.dout_en;
   assign tx_holding_ready_n_oe = s_q.txr_oe;
   assign rx_holding_ready_n_oe = s_q.rxr_oe;
   assign tx_empty_or_line_change_n_oe = s_q.emt_oe;
   assign tick_16x = s_q.t16;
   assign tx_bit_tick = s_q.txb;
   assign rx_bit_tick = s_q.rxb;
   assign dtr_n = s_q.dtr_n;
   assign rts_n = s_q.rts_n;
   assign tx_char = s_q.tx_holding_register;
   assign tx_char_full = s_q.thr_full;
   assign sync1_char = s_q.syn1;
   assign sync2_char = s_q.syn2;
   assign escape_char = s_q.dle;
   assign mode1 = s_q.mr1;
   // transmitter and receiver enables come from the command bits alone, not the modem lines
   assign tx_enable = s_q.cmd[CMD_TXEN];
   assign rx_enable = s_q.cmd[CMD_RXEN];

   // bus is driven only after a read with chip enable low
   property p_bus_hiz;
      @(posedge clk) disable iff (!rst_n_q)
      data_oe |-> $past(!ce_n && !rw);
   endproperty
   a_bus_hiz: assert property (p_bus_hiz) else $error("data bus driven without read select");

   // loading the holding register releases the tx ready line on the next edge
   property p_tx_holding_ready_n_load;
      @(posedge clk) disable iff (!rst_n_q)
      (wr && register_select == SEL_DATA && !tx_shift_take) |-> ##1 !tx_holding_ready_n_oe;
   endproperty
   a_tx_holding_ready_n_load: assert property (p_tx_holding_ready_n_load) else $error("tx ready not released on load");

   // a received character pulls rx ready low on the next edge
   property p_rx_set;
      @(posedge clk) disable iff (!rst_n_q)
      (rx_char_valid && s_q.cmd[CMD_RXEN]) |=> rx_holding_ready_n_oe;
   endproperty
   a_rx_set: assert property (p_rx_set) else $error("rx ready not asserted");

   // reading the holding register releases rx ready unless a new one arrives
   property p_rx_read;
      @(posedge clk) disable iff (!rst_n_q)
      (rd && register_select == SEL_DATA && !rx_char_valid) |=> !rx_holding_ready_n_oe;
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("rx ready held after read");

   // receiver disabled for two cycles leaves rx ready released
   property p_rx_off;
      @(posedge clk) disable iff (!rst_n_q)
      (!rx_enable && $past(!rx_enable)) |-> !rx_holding_ready_n_oe;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("rx ready low with receiver off");

   // a modem line change while enabled pulls the change line low on the next edge;
   // a later status read may legally release it, so only that edge is checked
   property p_line_change;
      @(posedge clk) disable iff (!rst_n_q)
      ((tx_enable || rx_enable) && ($changed(dsr_n) || $changed(dcd_n))) |=> tx_empty_or_line_change_n_oe;
   endproperty
   a_line_change: assert property (p_line_change) else $error("line change not flagged");

   // status read with transmitter empty keeps the line low
   property p_empty_hold;
      @(posedge clk) disable iff (!rst_n_q)
      (rd && register_select == SEL_SYNC && s_q.tx_emt && s_q.chg && !wr) |=> tx_empty_or_line_change_n_oe;
   endproperty
   a_empty_hold: assert property (p_empty_hold) else $error("empty line released while empty");

   // each 16x tick follows a reference edge at terminal count
   property p_tick_terminal;
      @(posedge clk) disable iff (!rst_n_q)
      tick_16x |-> ($past(s_q.bcnt) == '0) && $past(ref_edge);
   endproperty
   a_tick_terminal: assert property (p_tick_terminal) else $error("tick without terminal count");

   // receive bit strobe comes only in asynchronous mode, with a 16x tick
   property p_rx_async;
      @(posedge clk) disable iff (!rst_n_q)
      rx_bit_tick |-> tick_16x && $past(async_mode);
   endproperty
   a_rx_async: assert property (p_rx_async) else $error("rx bit strobe in sync mode");

   // fastest code reloads sixteen edges apart
   property p_div_fast;
      @(posedge clk) disable iff (!rst_n_q)
      (ref_edge && s_q.bcnt == '0 && s_q.mr2[3:0] == 4'hf) |=> (s_q.bcnt == 13'd15);
   endproperty
   a_div_fast: assert property (p_div_fast) else $error("wrong reload for fastest code");
endmodule

// ### dv/scb_cpu_model.sv
// Purpose: host cpu and modem stand-in for the host port
// Assumes: its signals change just after a rising clk edge
// Notes: a released data bus toggles every cycle so stale data never looks valid
`timescale 1ns/1ns
module scb_cpu_model (
   input wire logic clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output logic ce_n,
   output logic rw,
   output logic [1:0] register_select,
   output logic [7:0] data_in,
   output logic dsr_n,
   output logic dcd_n,
   output logic cts_n
);
   logic drv = 1'h0; // cpu drives the bus
   logic [7:0] wd = 8'h00; // write byte
   logic [7:0] last = 8'h00; // bus level a cycle ago
   // bus level seen by the port: device, cpu, else a changing pattern
   assign data_in = data_oe ? data_out : (drv ? wd : ~last);
   always @(posedge clk) last <= data_in;
   // idle host, modem holding carrier and clear-to-send low
   initial begin
      {ce_n, rw, register_select} = 4'h8;
      {dsr_n, dcd_n, cts_n} = 3'h0;
   end
   // one cycle: set after an edge, taken at the next, released after it
   task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d, input logic en);
      @(posedge clk);
      {ce_n, rw, register_select, wd, drv} <= {~en, w, a, d, w & en};
      @(posedge clk);
      {ce_n, drv} <= 2'h2;
      @(posedge clk);
   endtask
   // flip data set ready to cause a line change
   task automatic toggle_dsr;
      @(posedge clk);
      dsr_n <= ~dsr_n;
   endtask
   // flip carrier detect to cause a line change
   task automatic toggle_dcd;
      @(posedge clk);
      dcd_n <= ~dcd_n;
   endtask
endmodule

// ### dv/testbench.sv
// Purpose: self-checking bench for the host port
// Assumes: reference toggles every clk, one rising edge per two cycles
// Notes: reads are queued and judged when the port turns its bus on
`timescale 1ns/1ns
module testbench
   import scb_pkg::*;
;
   logic clk = 1'h0, resetn = 1'h0, baud_reference_clock = 1'h0;
   logic tx_shift_take = 1'h0, tx_shift_done = 1'h0, rx_char_valid = 1'h0; // core strobes
   logic [7:0] rx_char = 8'h00;
   logic ce_n, rw, dsr_n, dcd_n, cts_n, data_oe, tick_16x, tx_bit_tick, rx_bit_tick, dtr_n, rts_n;
   logic tx_holding_ready_n_oe, rx_holding_ready_n_oe, tx_empty_or_line_change_n_oe;
   logic tx_char_full, tx_enable, rx_enable;
   logic [1:0] register_select;
   logic [7:0] data_in, data_out, tx_char, sync1_char, sync2_char, escape_char, mode1;
   logic oe_prev = 1'h0; // bus drive a cycle ago
   logic [7:0] cmd_x, d, s0, s1, s2, m1, m2; // expected contents
   logic [8:0] exp_q[$]; // pending read results
   int errors = 0, checks_done = 0, n, k;
   localparam int DIVS [16] = '{6144, 4096, 2793, 2284, 2048, 1536, 1024, 512, 292, 256, 171, 154, 128, 64, 32, 16};
   scb_host_port uut (.clk, .resetn, .ce_n, .rw, .register_select, .data_in, .data_out, .data_oe,
      .tx_holding_ready_n_oe, .rx_holding_ready_n_oe, .tx_empty_or_line_change_n_oe, .baud_reference_clock,
      .tick_16x, .tx_bit_tick, .rx_bit_tick, .dsr_n, .dcd_n, .cts_n, .dtr_n, .rts_n, .tx_char, .tx_char_full,
      .tx_shift_take, .tx_shift_done, .rx_char_valid, .rx_char, .sync1_char, .sync2_char, .escape_char,
      .mode1, .tx_enable, .rx_enable);
   scb_cpu_model cpu (.clk, .data_out, .data_oe, .ce_n, .rw, .register_select, .data_in, .dsr_n, .dcd_n, .cts_n);
   always #4 clk = ~clk;
   always @(posedge clk) baud_reference_clock <= ~baud_reference_clock;
   // judge a read once, when the bus turns on; the 9-bit filler never matches a byte
   always @(posedge clk) begin
      oe_prev <= data_oe;
      if (data_oe === 1'h1 && oe_prev !== 1'h1)
         check(data_out, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff);
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task wt(input int c);
      repeat (c) @(posedge clk);
   endtask
   task wr(input logic [1:0] a, input logic [7:0] v);
      cpu.access(1'h1, a, v, 1'h1);
   endtask
   // note the expected byte before the read starts
   task rd(input logic [1:0] a, input logic [7:0] v);
      exp_q.push_back({1'h0, v});
      cpu.access(1'h0, a, 8'h00, 1'h1);
   endtask
   // a command read rewinds the mode pointer, so mode 1 is loaded first
   task setm(input logic [7:0] a, input logic [7:0] b);
      rd(SEL_CMD, cmd_x);
      wr(SEL_MODE, a);
      wr(SEL_MODE, b);
   endtask
   // one-cycle strobes toward the port: take, done, receive
   task pulse(input logic [2:0] m);
      @(posedge clk);
      {tx_shift_take, tx_shift_done, rx_char_valid} <= m;
      @(posedge clk);
      {tx_shift_take, tx_shift_done, rx_char_valid} <= 3'h0;
   endtask
   function logic pick(input int w);
      case (w)
         0: pick = tick_16x;
         1: pick = tx_bit_tick;
         default: pick = rx_bit_tick;
      endcase
   endfunction
   // cycles between two pulses, bounded so a dead divider cannot hang the run
   task gap(input int w, output int c);
      k = 0;
      c = 0;
      @(posedge clk); // skip a pulse launched before the new divisor was written
      while (pick(w) !== 1'h1 && k < 30000) begin
         @(posedge clk);
         k++;
      end
      @(posedge clk);
      while (pick(w) !== 1'h1 && c < 30000) begin
         @(posedge clk);
         c++;
      end
      c++;
   endtask
   initial begin
      n = $urandom(93753);
      wt(5);
      resetn <= 1'h1;
      wt(3);
      check({tx_holding_ready_n_oe, rx_holding_ready_n_oe, tx_empty_or_line_change_n_oe, dtr_n, rts_n,
         tx_enable, rx_enable, tx_char_full}, 8'h18);
      // deselected accesses leave everything alone and never drive the bus
      cpu.access(1'h1, SEL_SYNC, 8'h5a, 1'h0);
      cpu.access(1'h0, SEL_SYNC, 8'h00, 1'h0);
      check(sync1_char, 8'h00);
      cmd_x = 8'h27;
      wr(SEL_CMD, cmd_x);
      wt(2);
      check({dtr_n, rts_n, tx_enable, rx_enable, tx_holding_ready_n_oe}, 5'h07);
      rd(SEL_CMD, cmd_x);
      rd(SEL_SYNC, 8'hc1);
      s0 = 8'($urandom);
      s1 = 8'($urandom);
      s2 = 8'($urandom);
      wr(SEL_SYNC, s0);
      wr(SEL_SYNC, s1);
      wr(SEL_SYNC, s2);
      check({sync1_char, sync2_char, escape_char}, {s0, s1, s2});
      m1 = 8'($urandom);
      m2 = 8'($urandom);
      setm(m1, m2);
      check(mode1, m1);
      setm(m1, m2);
      rd(SEL_CMD, cmd_x);
      rd(SEL_MODE, m1);
      rd(SEL_MODE, m2);
      // holding register load, take, empty, then a line change
      d = 8'($urandom);
      wr(SEL_DATA, d);
      wt(2);
      check({tx_char, tx_char_full, tx_holding_ready_n_oe}, {d, 2'h2});
      pulse(3'h4);
      wt(2);
      check({tx_char_full, tx_holding_ready_n_oe}, 2'h1);
      pulse(3'h2);
      wt(2);
      check(tx_empty_or_line_change_n_oe, 1'h1);
      rd(SEL_SYNC, 8'hc5);
      wt(2);
      check(tx_empty_or_line_change_n_oe, 1'h1);
      wr(SEL_DATA, d);
      wt(2);
      check(tx_empty_or_line_change_n_oe, 1'h0);
      cpu.toggle_dsr;
      wt(3);
      check(tx_empty_or_line_change_n_oe, 1'h1);
      rd(SEL_SYNC, 8'h44);
      wt(2);
      check(tx_empty_or_line_change_n_oe, 1'h0);
      // carrier detect dropping and returning both count as a line change
      cpu.toggle_dcd;
      wt(3);
      check(tx_empty_or_line_change_n_oe, 1'h1);
      rd(SEL_SYNC, 8'h04);
      wt(2);
      check(tx_empty_or_line_change_n_oe, 1'h0);
      cpu.toggle_dcd;
      wt(3);
      check(tx_empty_or_line_change_n_oe, 1'h1);
      rd(SEL_SYNC, 8'h44);
      wt(2);
      check(tx_empty_or_line_change_n_oe, 1'h0);
      // received characters: read releases, receiver disable releases
      d = 8'($urandom);
      @(posedge clk);
      rx_char <= d;
      pulse(3'h1);
      wt(2);
      check(rx_holding_ready_n_oe, 1'h1);
      rd(SEL_DATA, d);
      wt(2);
      check(rx_holding_ready_n_oe, 1'h0);
      pulse(3'h1);
      wt(2);
      check(rx_holding_ready_n_oe, 1'h1);
      cmd_x = 8'h23;
      wr(SEL_CMD, cmd_x);
      wt(2);
      check({rx_holding_ready_n_oe, rx_enable}, 2'h0);
      // reset in mid-run acts at once, without a clock edge
      @(posedge clk);
      resetn <= 1'h0;
      #1;
      check({dtr_n, tx_enable, tx_char_full}, 3'h4);
      wt(2);
      resetn <= 1'h1;
      wt(3);
      cmd_x = 8'h00;
      rd(SEL_CMD, cmd_x);
      // fastest code: 16 reference edges, two cycles each, per 16x tick
      setm(8'h4e, 8'h0f);
      gap(1, n);
      check(n, 512);
      gap(2, n);
      check(n, 512);
      setm(8'h4c, 8'h0f);
      gap(1, n);
      check(n, 32);
      k = 0;
      repeat (600) begin
         @(posedge clk);
         k += int'(rx_bit_tick !== 1'h0);
      end
      check(k, 0);
      // rising divisors, so a leftover count never outlasts the new period
      for (int c = 15; c >= 0; c--) begin
         setm(8'h4e, c[7:0]);
         gap(0, n);
         check(n, 2 * DIVS[c]);
      end
      check(exp_q.size(), 0);
      report_and_stop;
   end
   // the whole run needs at most about 90000 cycles, most of it the divider sweep
   initial begin
      repeat (99000) @(posedge clk);
      errors++;
      report_and_stop;
   end
endmodule
